// ### rtl/lssc_pkg.sv
// package: constants and encodings of the link status and slot capability registers
//------------------------------------------------------------------------------
// Behaviour
// [RL1] link status is upper half of word D0h
// [RL2] speed field: 0001b 2.5G, 0010b 5G, reset 0010b
// [RL3] bits 25:20 show negotiated width, reset x1
// [RL4] training error set on failure, cleared in L0
// [RL5] training bit one while training, reset one
// [RL6] slot clock bit: connector clock, reset one
// [RL7] bit 29 one only in link active state
// [RL8] bandwidth flags reset zero, write one clears
// [RL9] slot capability word only on downstream ports
// [RL10] bit 0 attention button present, reset one
// [RL11] bit 1 power controller present, reset one
// [RL12] bit 2 retention latch sensor present, reset one
// [RL13] bit 3 attention indicator present, reset one
// [RL14] bit 4 power indicator present, reset one
// [RL15] bit 5 surprise removal possible, reset zero
// [RL16] slot clock and presence defaults preloadable
// [RL17] bit 30 managed change, bit 31 autonomous
// [RL18] downstream interrupt enables, read-only upstream
//------------------------------------------------------------------------------
package lssc_pkg;

  // configuration offsets
  localparam logic [11:0] LSSC_OFF_LINK = 12'h0D0;
  localparam logic [11:0] LSSC_OFF_SLOT = 12'h0D4;

  // field positions in the link word
  localparam int unsigned LSSC_POS_EN_MGMT = 10;
  localparam int unsigned LSSC_POS_EN_AUTO = 11;
  localparam int unsigned LSSC_POS_SPEED   = 16;
  localparam int unsigned LSSC_POS_WIDTH   = 20;
  localparam int unsigned LSSC_POS_TERR    = 26;
  localparam int unsigned LSSC_POS_TRAIN   = 27;
  localparam int unsigned LSSC_POS_SLOTCLK = 28;
  localparam int unsigned LSSC_POS_DLUP    = 29;
  localparam int unsigned LSSC_POS_BW_MGMT = 30;
  localparam int unsigned LSSC_POS_BW_AUTO = 31;

  // speed codes and reset values
  localparam logic [3:0] LSSC_SPEED_2G5   = 4'h1;
  localparam logic [3:0] LSSC_SPEED_5G    = 4'h2;
  localparam logic [3:0] LSSC_SPEED_RST   = 4'h2;
  localparam logic [5:0] LSSC_WIDTH_RST   = 6'h01;
  localparam logic       LSSC_SLOTCLK_RST = 1'b1;
  // caps bit5..0: surprise, pwr ind, attn ind, latch, pwr ctl, button
  localparam logic [5:0] LSSC_CAPS_RST    = 6'h1F;

  // link training progress, one-hot
  typedef enum logic [2:0] {
    LSSC_LT_TRAIN = 3'h1,
    LSSC_LT_L0    = 3'h2,
    LSSC_LT_FAIL  = 3'h4
  } lssc_lt_type;

endpackage

// ### rtl/lssc_sync3.sv
// module: three-stage synchroniser with agreement filter for a pin level
`timescale 1ns/1ns
module lssc_sync3
  import lssc_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic pinIn,
  output logic      levelOut
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic q;
  } lssc_sync_type;

  lssc_sync_type st_r;
  lssc_sync_type st_nxt;

  // s1 feeds only s2; the output follows once s2 and s3 agree
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = pinIn;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    if (st_r.s2 == st_r.s3) begin
      st_nxt.q = st_r.s3;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= '0;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign levelOut = st_r.q;

endmodule

// ### rtl/lssc_regs.sv
// module: per-port link status and slot capability registers of a switch port
`timescale 1ns/1ns
module lssc_regs
  import lssc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        cfgRdEn,
  input  wire logic        cfgWrEn,
  input  wire logic [11:0] cfgAddr,
  input  wire logic [3:0]  cfgByteEn,
  input  wire logic [31:0] cfgWrData,
  output logic      [31:0] cfgRdData,
  output logic             cfgRdValid,
  input  wire logic        portDownPin,
  input  wire logic        ltStart,
  input  wire logic        ltSuccess,
  input  wire logic        ltFail,
  input  wire logic        ltAutonomous,
  input  wire logic        linkGen2,
  input  wire logic [5:0]  linkWidthIn,
  input  wire logic        dataLinkUpState,
  input  wire logic        presetLoad,
  input  wire logic        presetSlotClk,
  input  wire logic [5:0]  presetSlotCaps,
  output logic             bwNotifyIrq
);

  //----------------------------------------------------------------------------
  // state
  //----------------------------------------------------------------------------

  typedef struct packed {
    lssc_lt_type lt;
    logic [3:0]  speed;
    logic [5:0]  width;
    logic        trainErr;
    logic        wasUp;
    logic        dlUp;
    logic        bwMgmt;
    logic        bwAuto;
    logic        slotClk;
    logic [5:0]  caps;
    logic        enMgmt;
    logic        enAuto;
    logic [31:0] rdData;
    logic        rdValid;
    logic        irq;
  } lssc_state_type;

  localparam lssc_state_type ST_RST = '{
    lt:       LSSC_LT_TRAIN,
    speed:    LSSC_SPEED_RST,
    width:    LSSC_WIDTH_RST,
    trainErr: 1'b0,
    wasUp:    1'b0,
    dlUp:     1'b0,
    bwMgmt:   1'b0,
    bwAuto:   1'b0,
    slotClk:  LSSC_SLOTCLK_RST,
    caps:     LSSC_CAPS_RST,
    enMgmt:   1'b0,
    enAuto:   1'b0,
    rdData:   32'h0000_0000,
    rdValid:  1'b0,
    irq:      1'b0
  };

  lssc_state_type st_r;
  lssc_state_type st_nxt;

  logic        isDown;
  logic [3:0]  newSpeed;
  logic        bwChange;
  logic        setMgmt;
  logic        setAuto;
  logic        wrLink;
  logic        clrMgmt;
  logic        clrAuto;
  logic [31:0] linkWord;
  logic [31:0] slotWord;

  // dword match on configuration addresses, low two bits ignored
  function automatic logic hitReg(input logic [11:0] addr, input logic [11:0] off);
    hitReg = (addr[11:2] == off[11:2]);
  endfunction

  //----------------------------------------------------------------------------
  // port role strap
  //----------------------------------------------------------------------------

  // the strap is a pin, so it is synchronised; reads as upstream until settled
  lssc_sync3 u_downSync (
    .clk      (clk),
    .rst      (rst),
    .ce       (ce),
    .pinIn    (portDownPin),
    .levelOut (isDown)
  );

  //----------------------------------------------------------------------------
  // event decode
  //----------------------------------------------------------------------------

  // only two legal codes exist, so the link reports a gen2 flag
  assign newSpeed = linkGen2 ? LSSC_SPEED_5G : LSSC_SPEED_2G5; // [RL2]

  // a change counts only against a previous trained state; the first
  // training after reset is the bring-up, not a bandwidth change
  assign bwChange = (st_r.lt == LSSC_LT_TRAIN) && ltSuccess && !ltFail && st_r.wasUp
                    && ((newSpeed != st_r.speed) || (linkWidthIn != st_r.width));
  assign setMgmt  = bwChange && !ltAutonomous; // [RL17]
  assign setAuto  = bwChange && ltAutonomous; // [RL17]

  // write-one-to-clear sits in the top byte lane
  assign wrLink  = cfgWrEn && hitReg(cfgAddr, LSSC_OFF_LINK);
  assign clrMgmt = wrLink && cfgByteEn[3] && cfgWrData[LSSC_POS_BW_MGMT]; // [RL8]
  assign clrAuto = wrLink && cfgByteEn[3] && cfgWrData[LSSC_POS_BW_AUTO]; // [RL8]

  //----------------------------------------------------------------------------
  // read words
  //----------------------------------------------------------------------------

  // status in the upper half; the lower half only carries the two enables
  always_comb begin
    linkWord = 32'h0000_0000;
    linkWord[LSSC_POS_EN_MGMT] = st_r.enMgmt; // [RL18]
    linkWord[LSSC_POS_EN_AUTO] = st_r.enAuto; // [RL18]
    linkWord[LSSC_POS_SPEED +: 4] = st_r.speed; // [RL1] [RL2]
    linkWord[LSSC_POS_WIDTH +: 6] = st_r.width; // [RL3]
    linkWord[LSSC_POS_TERR] = st_r.trainErr; // [RL4]
    linkWord[LSSC_POS_TRAIN] = (st_r.lt == LSSC_LT_TRAIN); // [RL5]
    linkWord[LSSC_POS_SLOTCLK] = st_r.slotClk; // [RL6]
    linkWord[LSSC_POS_DLUP] = st_r.dlUp; // [RL7]
    linkWord[LSSC_POS_BW_MGMT] = st_r.bwMgmt; // [RL8]
    linkWord[LSSC_POS_BW_AUTO] = st_r.bwAuto; // [RL8]
  end

  // the slot word is absent on the upstream port and reads as zero there
  always_comb begin
    slotWord = 32'h0000_0000;
    if (isDown) begin
      slotWord[5:0] = st_r.caps; // [RL9] [RL10] [RL11] [RL12] [RL13] [RL14] [RL15]
    end
  end

  //----------------------------------------------------------------------------
  // next state
  //----------------------------------------------------------------------------

  always_comb begin
    st_nxt         = st_r;
    st_nxt.rdValid = 1'b0;

    // training progress; a failure in the same cycle as success wins
    case (st_r.lt)
      LSSC_LT_TRAIN: begin
        if (ltFail) begin
          st_nxt.lt       = LSSC_LT_FAIL;
          st_nxt.trainErr = 1'b1; // [RL4]
        end else if (ltSuccess) begin
          st_nxt.lt       = LSSC_LT_L0; // [RL5]
          st_nxt.trainErr = 1'b0; // [RL4]
          st_nxt.speed    = newSpeed; // [RL2]
          st_nxt.width    = linkWidthIn; // [RL3]
          st_nxt.wasUp    = 1'b1;
        end
      end
      LSSC_LT_L0, LSSC_LT_FAIL: begin
        if (ltStart) begin
          st_nxt.lt = LSSC_LT_TRAIN; // [RL5]
        end
      end
      default: begin
        st_nxt.lt = LSSC_LT_TRAIN;
      end
    endcase

    // data link activity mirrors the control state machine
    st_nxt.dlUp = dataLinkUpState; // [RL7]

    // set wins over a clear in the same cycle
    st_nxt.bwMgmt = setMgmt || (st_r.bwMgmt && !clrMgmt); // [RL8] [RL17]
    st_nxt.bwAuto = setAuto || (st_r.bwAuto && !clrAuto); // [RL8] [RL17]

    // enables are writable only on a downstream port
    if (!isDown) begin
      st_nxt.enMgmt = 1'b0; // [RL18]
      st_nxt.enAuto = 1'b0; // [RL18]
    end else if (wrLink && cfgByteEn[1]) begin
      st_nxt.enMgmt = cfgWrData[LSSC_POS_EN_MGMT]; // [RL18]
      st_nxt.enAuto = cfgWrData[LSSC_POS_EN_AUTO]; // [RL18]
    end

    // loader overrides of the strapped defaults
    if (presetLoad) begin
      st_nxt.slotClk = presetSlotClk; // [RL16]
      st_nxt.caps    = presetSlotCaps; // [RL16]
    end

    // read data is registered; a same-cycle write shows on the next read
    if (cfgRdEn) begin
      st_nxt.rdValid = 1'b1;
      if (hitReg(cfgAddr, LSSC_OFF_LINK)) begin
        st_nxt.rdData = linkWord; // [RL1]
      end else if (hitReg(cfgAddr, LSSC_OFF_SLOT)) begin
        st_nxt.rdData = slotWord; // [RL9]
      end else begin
        st_nxt.rdData = 32'h0000_0000;
      end
    end

    // notification request to the port's interrupt logic
    st_nxt.irq = (st_r.bwMgmt && st_r.enMgmt) || (st_r.bwAuto && st_r.enAuto); // [RL18]
  end

  //----------------------------------------------------------------------------
  // registers
  //----------------------------------------------------------------------------

  // clock enable low freezes everything, including the read strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= ST_RST;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign cfgRdData   = st_r.rdData;
  assign cfgRdValid  = st_r.rdValid;
  assign bwNotifyIrq = st_r.irq;

  //----------------------------------------------------------------------------
  // checks
  //----------------------------------------------------------------------------

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  logic rdLink;
  logic rdSlot;
  assign rdLink = ce && cfgRdEn && hitReg(cfgAddr, LSSC_OFF_LINK);
  assign rdSlot = ce && cfgRdEn && hitReg(cfgAddr, LSSC_OFF_SLOT);

  speed_code_legal_a: assert property ( // [RL2]
    (st_r.speed == LSSC_SPEED_2G5) || (st_r.speed == LSSC_SPEED_5G))
    else $error("link speed code outside the two legal values");

  width_capture_a: assert property ( // [RL3]
    ce && (st_r.lt == LSSC_LT_TRAIN) && ltSuccess && !ltFail
    |=> st_r.width == $past(linkWidthIn))
    else $error("negotiated width not captured on training success");

  train_err_set_a: assert property ( // [RL4]
    ce && (st_r.lt == LSSC_LT_TRAIN) && ltFail
    |=> st_r.trainErr && (st_r.lt == LSSC_LT_FAIL))
    else $error("training failure did not raise the error bit");

  train_err_clr_a: assert property ( // [RL4]
    ce && (st_r.lt == LSSC_LT_TRAIN) && ltSuccess && !ltFail |=> !st_r.trainErr)
    else $error("error bit not cleared on reaching L0");

  training_read_a: assert property ( // [RL5]
    rdLink ##1 ce[*1]
    |-> cfgRdValid && (cfgRdData[LSSC_POS_TRAIN] == ($past(st_r.lt) == LSSC_LT_TRAIN)))
    else $error("training bit does not follow training progress");

  dl_up_read_a: assert property ( // [RL7]
    rdLink ##1 1'b1 |-> cfgRdData[LSSC_POS_DLUP] == $past(st_r.dlUp))
    else $error("link active bit read back wrong");

  w1c_clear_a: assert property ( // [RL8]
    ce && clrMgmt && !setMgmt |=> !st_r.bwMgmt)
    else $error("write one did not clear the managed flag");

  w0_keeps_a: assert property ( // [RL8]
    ce && st_r.bwAuto && !clrAuto |=> st_r.bwAuto)
    else $error("autonomous flag lost without a write of one");

  set_wins_a: assert property ( // [RL17]
    ce && setMgmt && clrMgmt |=> st_r.bwMgmt)
    else $error("managed change lost against a same-cycle clear");

  upstream_slot_a: assert property ( // [RL9]
    rdSlot && !isDown |=> cfgRdData == 32'h0000_0000)
    else $error("slot word visible on upstream port");

  preset_load_a: assert property ( // [RL16]
    ce && presetLoad |=> (st_r.slotClk == $past(presetSlotClk))
                         && (st_r.caps == $past(presetSlotCaps)))
    else $error("loader values not taken");

  irq_gate_a: assert property ( // [RL18]
    ce && st_r.bwAuto && st_r.enAuto |=> bwNotifyIrq)
    else $error("enabled autonomous flag did not request notification");

  upstream_en_a: assert property ( // [RL18]
    ce && !isDown |=> !st_r.enMgmt && !st_r.enAuto)
    else $error("interrupt enables writable on upstream port");

  // capture, restart and notification checks; the reset term keeps the
  // release edge out, where state is reset rather than loaded
  speed_capture_a: assert property ( // [RL2]
    ce && (st_r.lt == LSSC_LT_TRAIN) && ltSuccess && !ltFail
    |=> st_r.speed == ($past(linkGen2) ? LSSC_SPEED_5G : LSSC_SPEED_2G5))
    else $error("link speed not captured on training success");

  train_start_a: assert property ( // [RL5]
    ce && (st_r.lt != LSSC_LT_TRAIN) && ltStart |=> st_r.lt == LSSC_LT_TRAIN)
    else $error("training did not restart on request");

  dl_follow_a: assert property ( // [RL7]
    ce && !rst |=> st_r.dlUp == $past(dataLinkUpState))
    else $error("link active bit does not follow the data link state");

  auto_set_a: assert property ( // [RL17]
    ce && setAuto |=> st_r.bwAuto)
    else $error("autonomous change did not raise its flag");

  auto_clear_a: assert property ( // [RL8]
    ce && clrAuto && !setAuto |=> !st_r.bwAuto)
    else $error("write one did not clear the autonomous flag");

  slot_down_read_a: assert property ( // [RL9]
    rdSlot && isDown
    |=> cfgRdData == {26'h000_0000, $past(st_r.caps)})
    else $error("slot word wrong on downstream port");

  read_strobe_a: assert property ( // [RL1]
    ce && !rst && cfgRdEn |=> cfgRdValid)
    else $error("read request not answered");

  irq_drop_a: assert property ( // [RL18]
    ce && !st_r.bwMgmt && !st_r.bwAuto |=> !bwNotifyIrq)
    else $error("notification raised with both flags clear");

  // main scenarios the bench is expected to reach
  cov_retrain_c: cover property (ce && setMgmt);
  cov_set_clear_c: cover property (ce && setMgmt && clrMgmt);
  cov_autonomous_c: cover property (ce && setAuto ##[1:20] ce && clrAuto);
  cov_fail_c: cover property (ce && ltFail ##[1:50] ce && ltSuccess);
  cov_slot_read_c: cover property (rdSlot && isDown);

endmodule

// ### bench/lssc_regs_tb.sv
// testbench: self-checking bench for the link status and slot capability registers
`timescale 1ns/1ns
module lssc_regs_tb
  import lssc_pkg::*;
();
  //----------------------------------------------------------------------------
  // signals
  //----------------------------------------------------------------------------
  logic        clk;
  logic        rst;
  logic        ce;
  logic        cfgRdEn;
  logic        cfgWrEn;
  logic [11:0] cfgAddr;
  logic [3:0]  cfgByteEn;
  logic [31:0] cfgWrData;
  logic [31:0] cfgRdData;
  logic        cfgRdValid;
  logic        portDownPin;
  logic        ltStart;
  logic        ltSuccess;
  logic        ltFail;
  logic        ltAutonomous;
  logic        linkGen2;
  logic [5:0]  linkWidthIn;
  logic        dataLinkUpState;
  logic        presetLoad;
  logic        presetSlotClk;
  logic [5:0]  presetSlotCaps;
  logic        bwNotifyIrq;
  int          failCount;
  int          comparisons;
  logic [31:0] rdWord;

  lssc_regs u_dut (
    .clk(clk), .rst(rst), .ce(ce), .cfgRdEn(cfgRdEn), .cfgWrEn(cfgWrEn),
    .cfgAddr(cfgAddr), .cfgByteEn(cfgByteEn), .cfgWrData(cfgWrData),
    .cfgRdData(cfgRdData), .cfgRdValid(cfgRdValid), .portDownPin(portDownPin),
    .ltStart(ltStart), .ltSuccess(ltSuccess), .ltFail(ltFail),
    .ltAutonomous(ltAutonomous), .linkGen2(linkGen2), .linkWidthIn(linkWidthIn),
    .dataLinkUpState(dataLinkUpState), .presetLoad(presetLoad),
    .presetSlotClk(presetSlotClk), .presetSlotCaps(presetSlotCaps),
    .bwNotifyIrq(bwNotifyIrq)
  );

  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  //----------------------------------------------------------------------------
  // shared tasks
  //----------------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      failCount++;
      $display("[ERR] %0t %s: got %h expected %h", $time, msg, got, exp);
    end
  endtask

  // expected link word, lower half holds only the two interrupt enables
  function automatic logic [31:0] lw(input logic [1:0] bw, input logic dl, input logic sc,
                                     input logic tr, input logic te, input logic [5:0] w,
                                     input logic [3:0] s, input logic [1:0] en);
    return {bw, dl, sc, tr, te, w, s, 4'h0, en, 10'h000};
  endfunction

  // one read: request held for one taking edge, answer looked at in its cycle
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge clk);
    cfgRdEn <= 1'b1;
    cfgAddr <= a;
    @(posedge clk);
    cfgRdEn <= 1'b0;
    #1;
    chk({31'h0, cfgRdValid}, 32'h0000_0001, "read strobe");
    d = cfgRdData;
  endtask

  task automatic rdChk(input logic [11:0] a, input logic [31:0] exp, input string msg);
    logic [31:0] d;
    rd(a, d);
    chk(d, exp, msg);
  endtask

  task automatic wr(input logic [11:0] a, input logic [3:0] be, input logic [31:0] d);
    @(posedge clk);
    cfgWrEn   <= 1'b1;
    cfgAddr   <= a;
    cfgByteEn <= be;
    cfgWrData <= d;
    @(posedge clk);
    cfgWrEn <= 1'b0;
  endtask

  // link event pulse: 0 start, 1 success, 2 fail; speed and width stay as levels
  task automatic ev(input int k, input logic g, input logic [5:0] w, input logic au);
    @(posedge clk);
    ltStart      <= (k == 0);
    ltSuccess    <= (k == 1);
    ltFail       <= (k == 2);
    linkGen2     <= g;
    linkWidthIn  <= w;
    ltAutonomous <= au;
    @(posedge clk);
    ltStart   <= 1'b0;
    ltSuccess <= 1'b0;
    ltFail    <= 1'b0;
  endtask

  task automatic endSim();
    $display("comparisons %0d mismatches %0d", comparisons, failCount);
    if (failCount == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  //----------------------------------------------------------------------------
  // scenarios
  //----------------------------------------------------------------------------
  task automatic scnReset();
    rdChk(12'h0D0, 32'h1812_0000, "link reset");
    rdChk(12'h0D4, 32'h0000_001F, "slot reset");
  endtask

  // first training leaves no bandwidth flag since no earlier link existed
  task automatic scnTrain();
    @(posedge clk);
    dataLinkUpState <= 1'b1;
    ev(1, 1'b0, 6'h04, 1'b0);
    rdChk(12'h0D0, lw(2'b00, 1, 1, 0, 0, 6'h04, 4'h1, 2'b00), "first train");
    ev(0, 1'b0, 6'h04, 1'b0);
    rdChk(12'h0D0, lw(2'b00, 1, 1, 1, 0, 6'h04, 4'h1, 2'b00), "retraining");
    ev(2, 1'b0, 6'h04, 1'b0);
    rd(12'h0D0, rdWord);
    chk({31'h0, rdWord[LSSC_POS_TERR]}, 32'h1, "training error");
    @(posedge clk);
    dataLinkUpState <= 1'b0;
    ev(0, 1'b0, 6'h04, 1'b0);
    ev(1, 1'b0, 6'h04, 1'b0);
    rdChk(12'h0D0, lw(2'b00, 0, 1, 0, 0, 6'h04, 4'h1, 2'b00), "error cleared");
  endtask

  // managed then autonomous change, zero write ignored, one write clears
  task automatic scnBandwidth();
    wr(12'h0D0, 4'h2, 32'h0000_0C00);
    ev(0, 1'b0, 6'h04, 1'b0);
    ev(1, 1'b1, 6'h04, 1'b0);
    rdChk(12'h0D0, lw(2'b01, 0, 1, 0, 0, 6'h04, 4'h2, 2'b11), "managed flag");
    chk({31'h0, bwNotifyIrq}, 32'h1, "managed notify");
    wr(12'h0D0, 4'h8, 32'h0000_0000);
    rdChk(12'h0D0, lw(2'b01, 0, 1, 0, 0, 6'h04, 4'h2, 2'b11), "zero write");
    wr(12'h0D0, 4'h8, 32'h4000_0000);
    rdChk(12'h0D0, lw(2'b00, 0, 1, 0, 0, 6'h04, 4'h2, 2'b11), "managed clear");
    chk({31'h0, bwNotifyIrq}, 32'h0, "notify drops");
    ev(0, 1'b1, 6'h08, 1'b1);
    ev(1, 1'b1, 6'h08, 1'b1);
    rdChk(12'h0D0, lw(2'b10, 0, 1, 0, 0, 6'h08, 4'h2, 2'b11), "auto flag");
    chk({31'h0, bwNotifyIrq}, 32'h1, "auto notify");
    wr(12'h0D0, 4'h8, 32'hC000_0000);
    rdChk(12'h0D0, lw(2'b00, 0, 1, 0, 0, 6'h08, 4'h2, 2'b11), "auto clear");
  endtask

  // loader overrides the slot clock bit and the presence bits
  task automatic scnPreset();
    @(posedge clk);
    presetSlotClk  <= 1'b0;
    presetSlotCaps <= 6'h2A;
    presetLoad     <= 1'b1;
    @(posedge clk);
    presetLoad <= 1'b0;
    rdChk(12'h0D4, 32'h0000_002A, "slot preset");
    rdChk(12'h0D0, lw(2'b00, 0, 0, 0, 0, 6'h08, 4'h2, 2'b11), "clock preset");
  endtask

  // upstream strap hides the slot word and locks the enables at zero
  task automatic scnUpstream();
    @(posedge clk);
    portDownPin <= 1'b0;
    repeat (8) @(posedge clk);
    rdChk(12'h0D4, 32'h0000_0000, "upstream slot");
    rdChk(12'h0D0, lw(2'b00, 0, 0, 0, 0, 6'h08, 4'h2, 2'b00), "upstream enables");
    wr(12'h0D0, 4'h2, 32'h0000_0C00);
    rdChk(12'h0D0, lw(2'b00, 0, 0, 0, 0, 6'h08, 4'h2, 2'b00), "enables locked");
    rdChk(12'h0DC, 32'h0000_0000, "unmapped read");
  endtask

  // clock enable low swallows a retrain start; the read strobe stands one cycle
  task automatic scnFreeze();
    @(posedge clk);
    ce <= 1'b0;
    ev(0, 1'b1, 6'h08, 1'b0);
    @(posedge clk);
    ce <= 1'b1;
    rdChk(12'h0D0, lw(2'b00, 0, 0, 0, 0, 6'h08, 4'h2, 2'b00), "frozen start");
    @(posedge clk);
    #1;
    chk({31'h0, cfgRdValid}, 32'h0, "strobe drops");
  endtask

  // a width change and a clear of its flag in one cycle leave the flag set
  task automatic scnSetClear();
    ev(0, 1'b1, 6'h08, 1'b0);
    fork
      ev(1, 1'b1, 6'h04, 1'b0);
      wr(12'h0D0, 4'h8, 32'h4000_0000);
    join
    rdChk(12'h0D0, lw(2'b01, 0, 0, 0, 0, 6'h04, 4'h2, 2'b00), "set beats clear");
  endtask

  // reset in mid-run brings every field back, flags and loader values too
  task automatic scnRerst();
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rdChk(12'h0D0, 32'h1812_0000, "second reset");
    chk({31'h0, bwNotifyIrq}, 32'h0, "notify after reset");
  endtask

  //----------------------------------------------------------------------------
  // main sequence and watchdog
  //----------------------------------------------------------------------------
  initial begin
    failCount = 0;
    comparisons = 0;
    rst = 1'b1;
    ce = 1'b1;
    cfgRdEn = 1'b0;
    cfgWrEn = 1'b0;
    cfgAddr = 12'h000;
    cfgByteEn = 4'h0;
    cfgWrData = 32'h0000_0000;
    portDownPin = 1'b1;
    ltStart = 1'b0;
    ltSuccess = 1'b0;
    ltFail = 1'b0;
    ltAutonomous = 1'b0;
    linkGen2 = 1'b1;
    linkWidthIn = 6'h01;
    dataLinkUpState = 1'b0;
    presetLoad = 1'b0;
    presetSlotClk = 1'b1;
    presetSlotCaps = 6'h1F;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    // strap needs a few cycles to settle before the slot word shows
    repeat (8) @(posedge clk);
    scnReset();
    scnTrain();
    scnBandwidth();
    scnPreset();
    scnUpstream();
    scnFreeze();
    scnSetClear();
    scnRerst();
    endSim();
  end

  // whole run is about 120 cycles, so this only trips on a hang
  initial begin
    repeat (5000) @(posedge clk);
    failCount++;
    endSim();
  end
endmodule
